// [rtl/mss_pkg.sv]
// shared constants for the motion sensor serial port link
package mss_pkg;

    // core clock period of both ends
    localparam int CLK_NS = 100;

    // minimums round up, maximums down, never below one cycle
    function automatic int cyc_up(input longint t_ns);
        longint c;
        c = (t_ns + CLK_NS - 1) / CLK_NS;
        return (c < 1) ? 1 : int'(c);
    endfunction

    function automatic int cyc_dn(input longint t_ns);
        longint c;
        c = t_ns / CLK_NS;
        return (c < 1) ? 1 : int'(c);
    endfunction

    // link timing, each in its own unit
    localparam int F_SCLK_MAX_MHZ    = 2;
    localparam int T_NCS_SCLK_NS     = 120;
    localparam int T_SWW_US          = 120;
    localparam int T_SRW_US          = 20;
    localparam int T_SRAD_US         = 100;
    localparam int T_BEXIT_NS        = 500;
    localparam int T_HOLD_WR_US      = 20;
    localparam int T_HOLD_RD_NS      = 120;
    localparam int T_MOT_RST_MS      = 30;
    localparam int T_STDWN_MS        = 500;
    localparam int T_REST_S          = 1;

    // derived cycle counts
    localparam int SCLK_HALF_CYC = cyc_up(longint'(1000 / F_SCLK_MAX_MHZ) / 2);
    localparam int NCS_SCLK_CYC  = cyc_up(T_NCS_SCLK_NS);
    localparam int SWW_CYC       = cyc_up(longint'(T_SWW_US) * 1000);
    localparam int SRW_CYC       = cyc_up(longint'(T_SRW_US) * 1000);
    localparam int SRAD_CYC      = cyc_up(longint'(T_SRAD_US) * 1000);
    localparam int BEXIT_CYC     = cyc_up(T_BEXIT_NS);
    localparam int HOLD_WR_CYC   = cyc_up(longint'(T_HOLD_WR_US) * 1000);
    localparam int HOLD_RD_CYC   = cyc_up(T_HOLD_RD_NS);
    localparam int MOT_RST_CYC   = cyc_up(longint'(T_MOT_RST_MS) * 1000000);
    localparam int STDWN_CYC     = cyc_dn(longint'(T_STDWN_MS) * 1000000);
    localparam int REST_CYC      = cyc_dn(longint'(T_REST_S) * 1000000000);

    // host gap timer width
    localparam int HOST_TW = 11;

    // frame layout
    localparam int WR_DIR_BIT    = 7;
    localparam int BYTE_BITS     = 8;

endpackage

// [rtl/mss_link_if.sv]
// four-wire serial link between host and sensor port
`timescale 1ns/1ps
`default_nettype none
interface mss_link_if;
    logic sclk;
    logic port_select_n;
    logic mosi;
    logic miso;
    logic miso_oe;

    modport host (
        output sclk,
        output port_select_n,
        output mosi,
        input  miso,
        input  miso_oe
    );

    modport dev (
        input  sclk,
        input  port_select_n,
        input  mosi,
        output miso,
        output miso_oe
    );
endinterface
`default_nettype wire

// [rtl/mss_dev.sv]
// sensor end of the serial port: link-clocked shifter plus power state timing
`timescale 1ns/1ps
`default_nettype none
module mss_dev #(
    parameter int STDWN_CYC = mss_pkg::STDWN_CYC,
    parameter int REST_CYC  = mss_pkg::REST_CYC
) (
    // core clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    // link
    mss_link_if.dev         lnk,
    // register side
    input  wire logic [7:0] i_rd_data,
    output logic            o_wr_stb,
    output logic [6:0]      o_wr_addr,
    output logic [7:0]      o_wr_data,
    output logic            o_rd_stb,
    output logic [6:0]      o_rd_addr,
    // power state
    input  wire logic       i_shutdown,
    input  wire logic       i_forced_rest,
    output logic            o_low_power,
    output logic            o_motion_ok
);

    if (STDWN_CYC < 1 || REST_CYC < 1 || STDWN_CYC >= (1 << 30) || REST_CYC >= (1 << 30)) begin : g_chk
        $error("mss_dev: power counts out of range");
    end

    ////////////////////////////////////////////////////////////////////////////
    // link domain: select high clears the frame

    logic       frame_rst_n;
    logic [3:0] bit_ff;
    logic [7:0] in_ff;
    logic       is_wr_ff;
    logic       rd_ph_ff;
    logic       done_ff;
    logic [6:0] addr_hold_ff;
    logic [7:0] data_hold_ff;
    logic       wr_tgl_ff;
    logic       rd_tgl_ff;
    logic [2:0] nbit_ff;
    logic [7:0] out_ff;
    logic       miso_ff;
    logic       oe_ff;

    assign frame_rst_n = i_rst_n & ~lnk.port_select_n; // [R18]

    always_ff @(posedge lnk.sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            bit_ff   <= 4'h0;
            in_ff    <= 8'h00;
            is_wr_ff <= 1'b0;
            rd_ph_ff <= 1'b0;
            done_ff  <= 1'b0;
        end else if (!done_ff) begin
            in_ff  <= {in_ff[6:0], lnk.mosi}; // [R17]
            bit_ff <= bit_ff + 4'h1;
            if (bit_ff == 4'h7) begin
                if (in_ff[mss_pkg::WR_DIR_BIT - 1]) begin // [R16]
                    is_wr_ff <= 1'b1;
                end else begin
                    rd_ph_ff <= 1'b1;
                    done_ff  <= 1'b1;
                end
            end
            if (bit_ff == 4'hF) begin
                done_ff <= 1'b1; // [R16]
            end
        end
    end

    // crossing words outlive the frame reset
    always_ff @(posedge lnk.sclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            addr_hold_ff <= 7'h00;
            data_hold_ff <= 8'h00;
            wr_tgl_ff    <= 1'b0;
            rd_tgl_ff    <= 1'b0;
        end else if (!done_ff) begin
            if (bit_ff == 4'h7) begin
                addr_hold_ff <= {in_ff[5:0], lnk.mosi};
                if (!in_ff[mss_pkg::WR_DIR_BIT - 1]) begin
                    rd_tgl_ff <= ~rd_tgl_ff;
                end
            end
            if (bit_ff == 4'hF && is_wr_ff) begin
                data_hold_ff <= {in_ff[6:0], lnk.mosi}; // [R16]
                wr_tgl_ff    <= ~wr_tgl_ff;
            end
        end
    end

    // read data shifts out on falling edges
    always_ff @(negedge lnk.sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            nbit_ff <= 3'h0;
            out_ff  <= 8'h00;
            miso_ff <= 1'b0;
            oe_ff   <= 1'b0; // [R10]
        end else if (rd_ph_ff) begin
            oe_ff   <= 1'b1;
            nbit_ff <= nbit_ff + 3'h1;
            if (nbit_ff == 3'h0) begin
                miso_ff <= i_rd_data[7]; // [R9]
                out_ff  <= {i_rd_data[6:0], 1'b0};
            end else begin
                miso_ff <= out_ff[7]; // [R9]
                out_ff  <= {out_ff[6:0], 1'b0};
            end
        end
    end

    assign lnk.miso    = miso_ff;
    assign lnk.miso_oe = oe_ff;

    ////////////////////////////////////////////////////////////////////////////
    // core domain: toggles cross, words already stable

    logic [2:0] wr_sync_ff;
    logic [2:0] rd_sync_ff;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_sync_ff <= 3'h0;
            rd_sync_ff <= 3'h0;
        end else begin
            wr_sync_ff <= {wr_sync_ff[1:0], wr_tgl_ff};
            rd_sync_ff <= {rd_sync_ff[1:0], rd_tgl_ff};
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_wr_stb  <= 1'b0;
            o_wr_addr <= 7'h00;
            o_wr_data <= 8'h00;
            o_rd_stb  <= 1'b0;
            o_rd_addr <= 7'h00;
        end else begin
            o_wr_stb <= wr_sync_ff[2] ^ wr_sync_ff[1];
            o_rd_stb <= rd_sync_ff[2] ^ rd_sync_ff[1];
            if (wr_sync_ff[2] ^ wr_sync_ff[1]) begin
                o_wr_addr <= addr_hold_ff;
                o_wr_data <= data_hold_ff;
            end
            if (rd_sync_ff[2] ^ rd_sync_ff[1]) begin
                o_rd_addr <= addr_hold_ff;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // power state: entry and exit each finish inside their deadline

    typedef enum logic [1:0] {PW_RUN, PW_ENTER, PW_LOW, PW_WAKE} mss_pw_t;

    mss_pw_t     pw_ff;
    logic [29:0] pw_tmr_ff;
    logic        pw_req;

    assign pw_req = i_shutdown | i_forced_rest;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pw_ff       <= PW_RUN;
            pw_tmr_ff   <= 30'h0;
            o_low_power <= 1'b0;
            o_motion_ok <= 1'b1;
        end else begin
            unique case (pw_ff)
                PW_RUN: begin
                    if (pw_req) begin
                        pw_ff       <= PW_ENTER;
                        o_motion_ok <= 1'b0;
                        pw_tmr_ff   <= i_shutdown ? 30'(STDWN_CYC - 1) // [R13]
                                                  : 30'(REST_CYC - 1); // [R14]
                    end
                end
                PW_ENTER: begin
                    if (!pw_req) begin
                        pw_ff       <= PW_RUN;
                        o_motion_ok <= 1'b1;
                    end else if (pw_tmr_ff == 30'h0) begin
                        pw_ff       <= PW_LOW;
                        o_low_power <= 1'b1; // [R13] [R14]
                    end else begin
                        pw_tmr_ff <= pw_tmr_ff - 30'h1;
                    end
                end
                PW_LOW: begin
                    if (!pw_req) begin
                        pw_ff       <= PW_WAKE;
                        o_low_power <= 1'b0;
                        pw_tmr_ff   <= 30'(REST_CYC - 1); // [R15]
                    end
                end
                PW_WAKE: begin
                    if (pw_req) begin
                        pw_ff     <= PW_ENTER;
                        pw_tmr_ff <= i_shutdown ? 30'(STDWN_CYC - 1) : 30'(REST_CYC - 1);
                    end else if (pw_tmr_ff == 30'h0) begin
                        pw_ff       <= PW_RUN;
                        o_motion_ok <= 1'b1; // [R15]
                    end else begin
                        pw_tmr_ff <= pw_tmr_ff - 30'h1;
                    end
                end
            endcase
        end
    end

endmodule
`default_nettype wire

// [rtl/mss_host.sv]
// host end of the serial port: clock divider, framing and every link gap
//
// Functional notes
// [R1] host clock at most 2 MHz, even duty
// [R2] 120 us between consecutive write data bytes
// [R3] 120 us from write to read address
// [R4] 20 us after read before next command
// [R5] 100 us from address to read data
// [R6] 500 ns select high after burst
// [R7] select held 20 us after write
// [R8] select held 120 ns after read
// [R9] sensor drives data after falling clock edge
// [R10] sensor releases data after select high
// [R11] motion invalid 30 ms after soft reset
// [R12] reset on wake, motion invalid 30 ms
// [R13] shutdown reaches low current within 500 ms
// [R14] forced rest reaches low current within 1 s
// [R15] motion resumes within 1 s of rest exit
// [R16] write is address byte then data byte
// [R17] sensor samples data on rising edges
// [R18] select high aborts and clears the port
// [R19] select raised after burst ends burst
// [R20] host counts every gap in own cycles
`timescale 1ns/1ps
`default_nettype none
module mss_host #(
    parameter int         MOT_RST_CYC     = mss_pkg::MOT_RST_CYC,
    parameter logic [6:0] SOFT_RESET_ADDR = 7'h7F
) (
    // core clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    // command port
    input  wire logic       i_cmd_valid,
    input  wire logic       i_cmd_write,
    input  wire logic [6:0] i_cmd_addr,
    input  wire logic [7:0] i_cmd_data,
    input  wire logic [3:0] i_cmd_nbytes,
    output logic            o_cmd_ready,
    // read answers
    output logic            o_rd_valid,
    output logic [7:0]      o_rd_data,
    // motion data status
    output logic            o_motion_ok,
    // link
    mss_link_if.host        lnk
);

    localparam int TW = mss_pkg::HOST_TW;

    if (MOT_RST_CYC < 1 || MOT_RST_CYC >= (1 << 24)) begin : g_chk_mot
        $error("mss_host: MOT_RST_CYC out of range");
    end
    if (mss_pkg::SWW_CYC >= (1 << TW) || mss_pkg::SRAD_CYC >= (1 << TW)) begin : g_chk_tw
        $error("mss_host: gap timer too narrow");
    end
    if (mss_pkg::SCLK_HALF_CYC < 1 || mss_pkg::SCLK_HALF_CYC > 3) begin : g_chk_half
        $error("mss_host: clock half period out of range");
    end

    typedef enum logic [2:0] {
        HS_IDLE,
        HS_SETUP,
        HS_SHIFT,
        HS_ADDR_GAP,
        HS_HOLD,
        HS_GAP
    } mss_hs_t;

    ////////////////////////////////////////////////////////////////////////////
    // returned data crosses domains: two flops

    logic miso_m_ff;
    logic miso_s_ff;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            miso_m_ff <= 1'b0;
            miso_s_ff <= 1'b0;
        end else begin
            miso_m_ff <= lnk.miso;
            miso_s_ff <= miso_m_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // transaction sequencer

    mss_hs_t       st_ff;
    logic [TW-1:0] tmr_ff;
    logic [1:0]    half_ff;
    logic          sclk_ff;
    logic          ncs_ff;
    logic          mosi_ff;
    logic [7:0]    tx_ff;
    logic [7:0]    rx_ff;
    logic [2:0]    bit_ff;
    logic          data_ph_ff;
    logic          wr_ff;
    logic [7:0]    wdata_ff;
    logic [3:0]    left_ff;
    logic          burst_ff;
    logic [TW-1:0] gap_after_hold;
    logic [7:0]    rx_next;

    assign rx_next = {rx_ff[6:0], miso_s_ff};

    // gap after select high; for writes the hold counts toward it
    always_comb begin
        if (wr_ff) begin
            gap_after_hold = TW'(mss_pkg::SWW_CYC - mss_pkg::HOLD_WR_CYC); // [R2] [R3]
        end else if (burst_ff && mss_pkg::BEXIT_CYC > mss_pkg::SRW_CYC) begin
            gap_after_hold = TW'(mss_pkg::BEXIT_CYC); // [R6]
        end else begin
            gap_after_hold = TW'(mss_pkg::SRW_CYC); // [R4] [R6]
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_ff       <= HS_IDLE;
            tmr_ff      <= '0;
            half_ff     <= 2'h0;
            sclk_ff     <= 1'b1;
            ncs_ff      <= 1'b1;
            mosi_ff     <= 1'b0;
            tx_ff       <= 8'h00;
            rx_ff       <= 8'h00;
            bit_ff      <= 3'h0;
            data_ph_ff  <= 1'b0;
            wr_ff       <= 1'b0;
            wdata_ff    <= 8'h00;
            left_ff     <= 4'h0;
            burst_ff    <= 1'b0;
            o_cmd_ready <= 1'b1;
            o_rd_valid  <= 1'b0;
            o_rd_data   <= 8'h00;
        end else begin
            o_rd_valid <= 1'b0;
            unique case (st_ff)
                HS_IDLE: begin
                    if (i_cmd_valid) begin
                        o_cmd_ready <= 1'b0;
                        ncs_ff      <= 1'b0;
                        wr_ff       <= i_cmd_write;
                        wdata_ff    <= i_cmd_data;
                        tx_ff       <= {i_cmd_write, i_cmd_addr}; // [R16]
                        left_ff     <= (i_cmd_nbytes == 4'h0) ? 4'h1 : i_cmd_nbytes;
                        burst_ff    <= !i_cmd_write && i_cmd_nbytes > 4'h1;
                        data_ph_ff  <= 1'b0;
                        bit_ff      <= 3'h0;
                        tmr_ff      <= TW'(mss_pkg::NCS_SCLK_CYC);
                        st_ff       <= HS_SETUP;
                    end
                end
                HS_SETUP: begin
                    if (tmr_ff == TW'(1)) begin
                        st_ff   <= HS_SHIFT;
                        sclk_ff <= 1'b0;
                        mosi_ff <= tx_ff[7];
                        half_ff <= 2'(mss_pkg::SCLK_HALF_CYC);
                    end else begin
                        tmr_ff <= tmr_ff - TW'(1);
                    end
                end
                HS_SHIFT: begin
                    if (half_ff != 2'h1) begin
                        half_ff <= half_ff - 2'h1; // [R1]
                    end else if (!sclk_ff) begin
                        sclk_ff <= 1'b1; // [R1] [R17]
                        half_ff <= 2'(mss_pkg::SCLK_HALF_CYC);
                    end else begin
                        // end of the high phase: returned bit has settled
                        rx_ff   <= rx_next; // [R9]
                        half_ff <= 2'(mss_pkg::SCLK_HALF_CYC);
                        bit_ff  <= bit_ff + 3'h1;
                        if (bit_ff != 3'h7) begin
                            sclk_ff <= 1'b0;
                            mosi_ff <= tx_ff[6];
                            tx_ff   <= {tx_ff[6:0], 1'b0};
                        end else if (!data_ph_ff && wr_ff) begin
                            data_ph_ff <= 1'b1;
                            sclk_ff    <= 1'b0;
                            mosi_ff    <= wdata_ff[7]; // [R16]
                            tx_ff      <= wdata_ff;
                        end else if (!data_ph_ff) begin
                            data_ph_ff <= 1'b1;
                            tx_ff      <= 8'h00;
                            tmr_ff     <= TW'(mss_pkg::SRAD_CYC); // [R5]
                            st_ff      <= HS_ADDR_GAP;
                        end else if (wr_ff) begin
                            tmr_ff <= TW'(mss_pkg::HOLD_WR_CYC); // [R7]
                            st_ff  <= HS_HOLD;
                        end else begin
                            o_rd_valid <= 1'b1;
                            o_rd_data  <= rx_next;
                            left_ff    <= left_ff - 4'h1;
                            if (left_ff != 4'h1) begin
                                sclk_ff <= 1'b0;
                                mosi_ff <= 1'b0;
                            end else begin
                                tmr_ff <= TW'(mss_pkg::HOLD_RD_CYC); // [R8]
                                st_ff  <= HS_HOLD;
                            end
                        end
                    end
                end
                HS_ADDR_GAP: begin
                    if (tmr_ff == TW'(1)) begin
                        st_ff   <= HS_SHIFT;
                        sclk_ff <= 1'b0; // [R5]
                        mosi_ff <= 1'b0;
                    end else begin
                        tmr_ff <= tmr_ff - TW'(1);
                    end
                end
                HS_HOLD: begin
                    if (tmr_ff == TW'(1)) begin
                        ncs_ff <= 1'b1; // [R19]
                        tmr_ff <= gap_after_hold;
                        st_ff  <= HS_GAP;
                    end else begin
                        tmr_ff <= tmr_ff - TW'(1);
                    end
                end
                HS_GAP: begin
                    if (tmr_ff == TW'(1)) begin
                        o_cmd_ready <= 1'b1; // [R20]
                        st_ff       <= HS_IDLE;
                    end else begin
                        tmr_ff <= tmr_ff - TW'(1);
                    end
                end
            endcase
        end
    end

    assign lnk.sclk          = sclk_ff;
    assign lnk.port_select_n = ncs_ff;
    assign lnk.mosi          = mosi_ff;

    ////////////////////////////////////////////////////////////////////////////
    // motion settling after a soft reset write, which also ends a wake

    logic [23:0] mot_tmr_ff;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mot_tmr_ff  <= 24'(MOT_RST_CYC);
            o_motion_ok <= 1'b0;
        end else if (st_ff == HS_IDLE && i_cmd_valid && i_cmd_write
                     && i_cmd_addr == SOFT_RESET_ADDR) begin
            mot_tmr_ff  <= 24'(MOT_RST_CYC); // [R11] [R12]
            o_motion_ok <= 1'b0;
        end else if (mot_tmr_ff != 24'h0) begin
            mot_tmr_ff <= mot_tmr_ff - 24'h1;
        end else begin
            o_motion_ok <= 1'b1; // [R11]
        end
    end

endmodule
`default_nettype wire

// [sim/mss_link_props.sv]
// link timing checker
`timescale 1ns/1ps
`default_nettype none
module mss_link_props (
    // core clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // link wires
    input wire logic sclk,
    input wire logic port_select_n,
    input wire logic mosi,
    input wire logic miso,
    input wire logic miso_oe
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    logic [10:0] hi_cnt_ff;
    logic        rd_frame_ff;
    ////////////////////////////////////////////////////////////////////////////////
    // saturating count of clock high cycles
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) hi_cnt_ff <= 11'h000;
        else if (!sclk) hi_cnt_ff <= 11'h000;
        else if (hi_cnt_ff != 11'h7FF) hi_cnt_ff <= hi_cnt_ff + 11'h001;
    end
    // read frame: sensor has driven data
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) rd_frame_ff <= 1'b0;
        else if (port_select_n) rd_frame_ff <= 1'b0;
        else if (miso_oe) rd_frame_ff <= 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////////////
    sequence s_low_phase; (!sclk) [*3] ##1 sclk; endsequence
    sequence s_high_phase; sclk [*3]; endsequence
    property p_idle; !sclk |-> !port_select_n; endproperty
    property p_low; $fell(sclk) |-> s_low_phase; endproperty
    property p_high; $rose(sclk) |-> s_high_phase; endproperty
    property p_wr_hold;
        $rose(port_select_n) && !rd_frame_ff |-> hi_cnt_ff >= 11'(mss_pkg::HOLD_WR_CYC);
    endproperty
    property p_rd_hold;
        $rose(port_select_n) && rd_frame_ff |-> hi_cnt_ff >= 11'(mss_pkg::HOLD_RD_CYC);
    endproperty
    property p_srad;
        $rose(miso_oe) |-> hi_cnt_ff >= 11'(mss_pkg::SRAD_CYC);
    endproperty
    property p_bexit; $rose(port_select_n) |-> port_select_n [*5]; endproperty
    property p_release; $rose(port_select_n) |-> ##[0:4] !miso_oe; endproperty
    property p_miso_hold; miso_oe && $past(miso_oe) && $changed(miso) |-> !sclk; endproperty
    property p_mosi_hold; $changed(mosi) |-> !sclk; endproperty
    a_idle: assert property (p_idle) else $error("clock low outside frame");
    a_low: assert property (p_low) else $error("clock low phase wrong");
    a_high: assert property (p_high) else $error("clock high too short");
    a_wr_hold: assert property (p_wr_hold) else $error("write hold short");
    a_rd_hold: assert property (p_rd_hold) else $error("read hold short");
    a_srad: assert property (p_srad) else $error("read data too early");
    a_bexit: assert property (p_bexit) else $error("select high too short");
    a_release: assert property (p_release) else $error("data out not released");
    a_miso_hold: assert property (p_miso_hold) else $error("data out moved while high");
    a_mosi_hold: assert property (p_mosi_hold) else $error("host data moved while high");
endmodule
`default_nettype wire

// [sim/tb_motion_sensor_serial_port_timing.sv]
// bench: host and sensor joined over the link
`timescale 1ns/1ps
`default_nettype none
module tb_motion_sensor_serial_port_timing;
    localparam int MOT = 50;
    localparam int SLP = 20;
    logic       i_clk = 1'b0;
    logic       i_rst_n = 1'b0;
    logic       cmd_valid = 1'b0;
    logic       cmd_write = 1'b0;
    logic [6:0] cmd_addr = 7'h00;
    logic [7:0] cmd_data = 8'h00;
    logic [3:0] cmd_nbytes = 4'h0;
    logic [7:0] rd_byte = 8'h00;
    logic       shutdown = 1'b0;
    logic       frest = 1'b0;
    logic       cmd_ready, rd_valid, host_mot, wr_stb, rd_stb, dev_lowp, dev_mot;
    logic [7:0] rd_data, wr_data;
    logic [6:0] wr_addr, rd_addr;
    int         n_fail = 0;
    int         comparisons = 0;
    int         cyc = 0;
    int         n_rd = 0;
    time        t0 = 0;
    ////////////////////////////////////////////////////////////////////////////////
    always #50 i_clk = ~i_clk;
    mss_link_if u_mss_link_if ();
    mss_host #(.MOT_RST_CYC(MOT)) u_mss_host (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_cmd_valid(cmd_valid), .i_cmd_write(cmd_write),
        .i_cmd_addr(cmd_addr), .i_cmd_data(cmd_data), .i_cmd_nbytes(cmd_nbytes),
        .o_cmd_ready(cmd_ready), .o_rd_valid(rd_valid), .o_rd_data(rd_data),
        .o_motion_ok(host_mot), .lnk(u_mss_link_if));
    mss_dev #(.STDWN_CYC(SLP), .REST_CYC(SLP)) u_mss_dev (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .lnk(u_mss_link_if), .i_rd_data(rd_byte),
        .o_wr_stb(wr_stb), .o_wr_addr(wr_addr), .o_wr_data(wr_data), .o_rd_stb(rd_stb),
        .o_rd_addr(rd_addr), .i_shutdown(shutdown), .i_forced_rest(frest),
        .o_low_power(dev_lowp), .o_motion_ok(dev_mot));
    mss_link_props u_mss_link_props (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .sclk(u_mss_link_if.sclk),
        .port_select_n(u_mss_link_if.port_select_n), .mosi(u_mss_link_if.mosi),
        .miso(u_mss_link_if.miso), .miso_oe(u_mss_link_if.miso_oe));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string nm);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic cmd(input logic wr, input logic [6:0] a, input logic [7:0] d,
                       input logic [3:0] nb);
        @(posedge i_clk iff cmd_ready === 1'b1);
        cmd_valid  <= 1'b1;
        cmd_write  <= wr;
        cmd_addr   <= a;
        cmd_data   <= d;
        cmd_nbytes <= nb;
        @(posedge i_clk);
        cmd_valid  <= 1'b0;
    endtask
    function automatic logic pick(input int s);
        return s == 0 ? host_mot : s == 1 ? dev_mot : dev_lowp;
    endfunction
    task automatic cnt(input int s, input logic lvl, output int n);
        n = 0;
        while (pick(s) !== lvl) begin
            @(posedge i_clk);
            #1;
            n++;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // tests take under 8000 cycles
    always @(posedge i_clk) begin
        cyc++;
        if (rd_valid === 1'b1) n_rd++;
        if (cyc == 20000) begin
            n_fail++;
            stop_test();
        end
    end
    initial begin
        int n;
        int k;
        repeat (2) @(posedge i_clk);
        i_rst_n <= 1'b1;
        cnt(0, 1'b1, n);
        chk(16'(n >= MOT), 16'h0001, "motion after reset");
        for (int i = 0; i < 2; i++) begin
            cmd(1'b1, i ? 7'h55 : 7'h12, i ? 8'h5A : 8'hA5, 4'h0);
            @(posedge i_clk iff wr_stb === 1'b1);
            chk(16'(wr_addr), i ? 16'h0055 : 16'h0012, "wr addr");
            chk(16'(wr_data), i ? 16'h005A : 16'h00A5, "wr data");
            if (i == 1) chk(16'($time - t0 >= 119900), 16'h0001, "wr gap");
            t0 = $time;
        end
        $display("write test done");
        for (int i = 1; i < 4; i += 2) begin
            rd_byte <= i == 1 ? 8'h3C : 8'hC3;
            k = n_rd;
            cmd(1'b0, 7'h05, 8'h00, 4'(i));
            @(posedge i_clk iff rd_stb === 1'b1);
            chk(16'(rd_addr), 16'h0005, "rd addr");
            if (i == 1) chk(16'($time - t0 >= 119900), 16'h0001, "wr to rd gap");
            repeat (i) begin
                @(posedge i_clk iff rd_valid === 1'b1);
                chk(16'(rd_data), 16'(rd_byte), "rd data");
            end
            @(posedge i_clk iff cmd_ready === 1'b1);
            chk(16'(n_rd - k), 16'(i), "rd byte count");
        end
        $display("read test done");
        cmd(1'b1, 7'h7F, 8'h5A, 4'h0);
        cnt(0, 1'b0, n);
        cnt(0, 1'b1, n);
        chk(16'(n >= MOT), 16'h0001, "motion after soft reset");
        $display("soft reset test done");
        for (int i = 0; i < 2; i++) begin
            @(posedge i_clk);
            shutdown <= (i == 0);
            frest    <= (i == 1);
            cnt(2, 1'b1, n);
            chk(16'(dev_mot), 16'h0000, "motion in low power");
            chk(16'(n >= SLP - 1 && n <= SLP + 1), 16'h0001, "time to low power");
            @(posedge i_clk);
            shutdown <= 1'b0;
            frest    <= 1'b0;
            cnt(1, 1'b1, n);
            chk(16'(n <= SLP + 2), 16'h0001, "time to motion");
            chk(16'(dev_lowp), 16'h0000, "low power left");
        end
        $display("power test done");
        stop_test();
    end
endmodule
`default_nettype wire
